//--- pkg/ppdm_regs.svh
`ifndef PPDM_REGS_SVH
`define PPDM_REGS_SVH

// ==========================================================
// register byte offsets
`define PPDM_OFS_CTRL    8'h00
`define PPDM_OFS_PERIOD  8'h04
`define PPDM_OFS_MAKER   8'h08
`define PPDM_OFS_PART    8'h0C
`define PPDM_OFS_PSTAT   8'h10
`define PPDM_OFS_SSTAT   8'h14
`define PPDM_OFS_SCHK    8'h18

// ==========================================================
// field positions
`define PPDM_POL_MSB     1
`define PPDM_POL_LSB     0
`define PPDM_SWAP_MSB    3
`define PPDM_SWAP_LSB    2
`define PPDM_MODE_MSB    6
`define PPDM_MODE_LSB    4
`define PPDM_CHECK_MSB   10
`define PPDM_CHECK_LSB   8
`define PPDM_MAPLEN_MSB  21
`define PPDM_MAPLEN_LSB  16
`define PPDM_CODE_MSB    7
`define PPDM_CODE_LSB    0
`define PPDM_MAKER_MSB   15
`define PPDM_PART_MSB    23
`define PPDM_UNITS_MSB   11
`define PPDM_LINK_MSB    17
`define PPDM_LINK_LSB    16
`define PPDM_FAULT_BIT   18
`define PPDM_SVALID_BIT  0
`define PPDM_SEN_BIT     1
`define PPDM_ACT_MSB     5
`define PPDM_ACT_LSB     4
`define PPDM_MULT_MSB    5
`define PPDM_BASE_MSB    7
`define PPDM_BASE_LSB    6
`define PPDM_BYTE_W      8

// ==========================================================
// reset values
`define PPDM_MAKER_RST   16'h0001
`define PPDM_PART_RST    24'h000001
`define PPDM_CODE_RST    8'h00

// ==========================================================
// timing, times in microseconds except the clock period in nanoseconds
`define PPDM_CLK_NS        40
`define PPDM_BASE_US       100
`define PPDM_BASE_CYC      ((`PPDM_BASE_US * 1000) / `PPDM_CLK_NS)
`define PPDM_T_MIN_US      400
`define PPDM_T_B1_OFS_US   6400
`define PPDM_T_B1_STEP_US  400
`define PPDM_T_B2_OFS_US   32000
`define PPDM_T_B2_STEP_US  1600
`define PPDM_T_MAX_US      132800
`define PPDM_CODE_CLAMP_LO 8'h03
`define PPDM_CODE_CLAMP_HI 8'hC0

// ==========================================================
// bus answers
`define PPDM_RESP_OKAY   2'h0
`define PPDM_RESP_SLVERR 2'h2

`endif

//--- pkg/ppdm_pkg.sv
package ppdm_pkg;
	typedef enum logic [1:0] {POL_KEEPVALID = 2'h0, POL_HOLD = 2'h1, POL_MARKINVALID = 2'h2} ppdm_pol_t;
	typedef enum logic [1:0] {SW_DIRECT = 2'h0, SW_HALF = 2'h1, SW_WORD = 2'h2, SW_FULL = 2'h3} ppdm_swap_t;
	typedef enum logic [2:0] {MODE_OFF = 3'h0, MODE_MANUAL = 3'h1, MODE_AUTO = 3'h2,
		MODE_DIN = 3'h3, MODE_DOUT = 3'h4} ppdm_mode_t;
	typedef enum logic [2:0] {CHK_NONE = 3'h0, CHK_V10 = 3'h1, CHK_V11 = 3'h2,
		CHK_BACKUP_RESTORE = 3'h3, CHK_RESTORE = 3'h4} ppdm_check_t;
	typedef enum logic [1:0] {ACT_NONE = 2'h0, ACT_CLEAR = 2'h1, ACT_BACKUP = 2'h2, ACT_RESTORE = 2'h3} ppdm_act_t;
	// gray along idle -> active -> fault
	typedef enum logic [1:0] {LINK_IDLE = 2'h0, LINK_ACTIVE = 2'h1, LINK_FAULT = 2'h3} ppdm_link_t;
	typedef logic [5:0] ppdm_len_t;

	typedef struct packed {
		ppdm_pol_t   pol;
		ppdm_swap_t  swap;
		ppdm_mode_t  mode;
		ppdm_check_t check;
		ppdm_len_t   mapLen;
	} ppdm_ctrl_t;

	typedef struct packed {
		logic [15:0] maker;
		logic [23:0] part;
	} ppdm_ident_t;

	typedef struct packed {
		logic        start;
		logic        down;
		logic        backupReq;
		logic [31:0] checksum;
	} ppdm_start_t;
endpackage

//--- rtl/ppdm_top.sv
`include "ppdm_regs.svh"

// Behaviour
// - clear_keep_valid: fieldbus down or idle gives zero outputs, valid kept high.
// - hold: fieldbus down or idle keeps last received outputs, valid high.
// - clear_mark_invalid: fieldbus down or idle gives zero outputs, valid low.
// - order_halfword swaps bytes in each 16-bit group; direct passes through.
// - order_word reverses the four bytes of each 32-bit group.
// - full swap reverses byte order of the whole mapped field.
// - a two-byte mapping field is never swapped by order_word.
// - short device data is zero filled, then the whole field swapped.
// - period code zero selects automatic, device minimum cycle time.
// - automatic or too small period runs at the least allowed time.
// - period code: low six bits multiplier, top two bits time base.
// - base 00: multiplier times 0.1 ms.
// - base 01: 6.4 ms plus multiplier times 0.4 ms.
// - base 10: 32.0 ms plus multiplier times 1.6 ms.
// - codes 1 to 3 give 0.4 ms, codes 192 to 255 give 132.8 ms.
// - parameter_store enabled only in manual mode with a backup-restore or restore-only check.
// - start-up with check none, V1.0 or V1.1 clears the store.
// - backup-restore: backup if empty or requested, restore on checksum mismatch.
// - restore-only: restore only if data stored and checksums differ.
// - changing expected maker_code or part_code clears the store.
// - leaving manual mode forces check none and clears the store.
// - manual mode with a check other than none compares identity before start; autostart starts directly.
// - hold 16-bit maker_code and 24-bit part_code for identity comparison.
module ppdm_top import ppdm_pkg::*; #(
	parameter int MAP_BYTES   = 16,
	parameter int BASE_CYCLES = `PPDM_BASE_CYC
) (
	// clock and reset
	input  wire logic                   mclk,
	input  wire logic                   reset,
	// register bus
	input  wire logic [7:0]             s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [7:0]             s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	// upstream mapping field
	input  wire logic                   upConnOk,
	input  wire logic                   upOutStrobe,
	input  wire logic [8*MAP_BYTES-1:0] upOutData,
	output logic [8*MAP_BYTES-1:0]      upInData,
	// connected device cyclic_payload
	input  wire logic [8*MAP_BYTES-1:0] devInData,
	input  wire ppdm_len_t              devLen,
	input  wire logic [11:0]            devMinCycle,
	output logic [8*MAP_BYTES-1:0]      devOutData,
	output logic                        devOutValid,
	// link start-up
	input  wire ppdm_start_t            linkEvt,
	input  wire ppdm_ident_t            devIdent,
	output logic                        startComm,
	output logic                        identFault,
	output logic                        doBackup,
	output logic                        doRestore,
	output logic [11:0]                 periodUnits,
	output logic                        cycleTick
);
	localparam int DW = 8 * MAP_BYTES;
	localparam int CW = $clog2(BASE_CYCLES + 1);
	localparam logic [11:0] MIN_U  = 12'(`PPDM_T_MIN_US / `PPDM_BASE_US);
	localparam logic [11:0] B1_OFS = 12'(`PPDM_T_B1_OFS_US / `PPDM_BASE_US);
	localparam logic [11:0] B1_STP = 12'(`PPDM_T_B1_STEP_US / `PPDM_BASE_US);
	localparam logic [11:0] B2_OFS = 12'(`PPDM_T_B2_OFS_US / `PPDM_BASE_US);
	localparam logic [11:0] B2_STP = 12'(`PPDM_T_B2_STEP_US / `PPDM_BASE_US);
	localparam logic [11:0] MAX_U  = 12'(`PPDM_T_MAX_US / `PPDM_BASE_US);

	typedef struct packed {
		logic            awReady;
		logic            wReady;
		logic            arReady;
		logic            awHeld;
		logic [7:0]      awAddr;
		logic            wHeld;
		logic [31:0]     wData;
		logic [3:0]      wStrb;
		logic            bvalid;
		logic [1:0]      bresp;
		logic            rvalid;
		logic [31:0]     rdata;
		logic [1:0]      rresp;
		ppdm_ctrl_t      ctrl;
		logic [7:0]      periodCode;
		ppdm_ident_t     ident;
		logic [DW-1:0]   lastOut;
		logic [DW-1:0]   devOut;
		logic            devOutValid;
		logic [DW-1:0]   upIn;
		logic [11:0]     periodUnits;
		logic [CW-1:0]   subCnt;
		logic [11:0]     unitCnt;
		logic            cycleTick;
		ppdm_link_t      link;
		logic            identFault;
		logic            startComm;
		logic            doBackup;
		logic            doRestore;
		logic            storedValid;
		logic [31:0]     storedChecksum;
		ppdm_act_t       lastAction;
	} ppdm_state_t;

	function automatic ppdm_state_t rstState();
		ppdm_state_t s;
		s = '0;
		s.ctrl.pol    = POL_MARKINVALID;
		s.ctrl.mapLen = ppdm_len_t'(MAP_BYTES);
		s.ident.maker = `PPDM_MAKER_RST;
		s.ident.part  = `PPDM_PART_RST;
		s.periodCode  = `PPDM_CODE_RST;
		return s;
	endfunction
	localparam ppdm_state_t RST_ST = rstState();

	ppdm_state_t st;
	ppdm_state_t next_st;

	// ==========================================================
	// byte ordering
	// bytes at or above pre are zero before the swap, at or above post after it
	function automatic logic [DW-1:0] swapField(input logic [DW-1:0] d, input ppdm_swap_t m,
			input ppdm_len_t lenMap, input ppdm_len_t pre, input ppdm_len_t post);
		logic [DW-1:0] r;
		int            src;
		r = '0;
		for (int i = 0; i < MAP_BYTES; i++) begin
			case (m)
				SW_HALF: src = i ^ 1;
				SW_WORD: src = (lenMap > 6'h02) ? (i ^ 3) : i;
				SW_FULL: src = int'(lenMap) - 1 - i;
				default: src = i;
			endcase
			if (i < int'(lenMap) && i < int'(post) && src >= 0 && src < int'(lenMap) && src < int'(pre)
					&& src < MAP_BYTES) begin
				r[`PPDM_BYTE_W*i +: `PPDM_BYTE_W] = d[`PPDM_BYTE_W*src +: `PPDM_BYTE_W];
			end
		end
		return r;
	endfunction

	// ==========================================================
	// period code decode, result in 0.1 ms units
	function automatic logic [11:0] periodDecode(input logic [7:0] code, input logic [11:0] devMin);
		logic [11:0] u;
		logic [11:0] mult;
		logic [11:0] floorU;
		mult = 12'(code[`PPDM_MULT_MSB:0]);
		case (code[`PPDM_BASE_MSB:`PPDM_BASE_LSB])
			2'h0: u = mult;
			2'h1: u = B1_OFS + mult * B1_STP;
			2'h2: u = B2_OFS + mult * B2_STP;
			default: u = MAX_U;
		endcase
		if (code == 8'h00) begin
			u = 12'h000;
		end else if (code <= `PPDM_CODE_CLAMP_LO) begin
			u = MIN_U;
		end
		floorU = (devMin > MIN_U) ? devMin : MIN_U;
		if (u <= floorU) begin
			u = floorU;
		end
		return u;
	endfunction

	// ==========================================================
	// register images
	function automatic logic [31:0] ctrlImage(input ppdm_ctrl_t c);
		logic [31:0] r;
		r = '0;
		r[`PPDM_POL_MSB:`PPDM_POL_LSB]       = c.pol;
		r[`PPDM_SWAP_MSB:`PPDM_SWAP_LSB]     = c.swap;
		r[`PPDM_MODE_MSB:`PPDM_MODE_LSB]     = c.mode;
		r[`PPDM_CHECK_MSB:`PPDM_CHECK_LSB]   = c.check;
		r[`PPDM_MAPLEN_MSB:`PPDM_MAPLEN_LSB] = c.mapLen;
		return r;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[`PPDM_BYTE_W*b +: `PPDM_BYTE_W] = n[`PPDM_BYTE_W*b +: `PPDM_BYTE_W];
			end
		end
		return r;
	endfunction

	// ==========================================================
	// next state
	always_comb begin
		logic [31:0] img;
		logic [31:0] mrg;
		logic        clearStore;
		logic        storeEnable;
		logic        hit;
		img         = '0;
		mrg         = '0;
		clearStore  = 1'b0;
		storeEnable = 1'b0;
		hit         = 1'b1;
		next_st     = st;
		next_st.startComm = 1'b0;
		next_st.doBackup  = 1'b0;
		next_st.doRestore = 1'b0;
		next_st.cycleTick = 1'b0;

		// write address and data, either order
		if (st.awReady && s_axi_awvalid) begin
			next_st.awHeld = 1'b1;
			next_st.awAddr = s_axi_awaddr;
		end
		if (st.wReady && s_axi_wvalid) begin
			next_st.wHeld = 1'b1;
			next_st.wData = s_axi_wdata;
			next_st.wStrb = s_axi_wstrb;
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		if (st.awHeld && st.wHeld) begin
			next_st.awHeld = 1'b0;
			next_st.wHeld  = 1'b0;
			next_st.bvalid = 1'b1;
			case (st.awAddr)
				`PPDM_OFS_CTRL: img = ctrlImage(st.ctrl);
				`PPDM_OFS_PERIOD: img = 32'(st.periodCode);
				`PPDM_OFS_MAKER: img = 32'(st.ident.maker);
				`PPDM_OFS_PART: img = 32'(st.ident.part);
				`PPDM_OFS_PSTAT, `PPDM_OFS_SSTAT, `PPDM_OFS_SCHK: img = '0;
				default: hit = 1'b0;
			endcase
			mrg = merge(img, st.wData, st.wStrb);
			next_st.bresp = hit ? `PPDM_RESP_OKAY : `PPDM_RESP_SLVERR;
			case (st.awAddr)
				`PPDM_OFS_CTRL: begin
					next_st.ctrl.pol    = ppdm_pol_t'(mrg[`PPDM_POL_MSB:`PPDM_POL_LSB]);
					next_st.ctrl.swap   = ppdm_swap_t'(mrg[`PPDM_SWAP_MSB:`PPDM_SWAP_LSB]);
					next_st.ctrl.mode   = ppdm_mode_t'(mrg[`PPDM_MODE_MSB:`PPDM_MODE_LSB]);
					next_st.ctrl.check  = ppdm_check_t'(mrg[`PPDM_CHECK_MSB:`PPDM_CHECK_LSB]);
					next_st.ctrl.mapLen = mrg[`PPDM_MAPLEN_MSB:`PPDM_MAPLEN_LSB];
					if (st.ctrl.mode == MODE_MANUAL && next_st.ctrl.mode != MODE_MANUAL) begin
						next_st.ctrl.check = CHK_NONE;
						clearStore = 1'b1;
					end
				end
				`PPDM_OFS_PERIOD: next_st.periodCode = mrg[`PPDM_CODE_MSB:`PPDM_CODE_LSB];
				`PPDM_OFS_MAKER: begin
					next_st.ident.maker = mrg[`PPDM_MAKER_MSB:0];
					clearStore = (mrg[`PPDM_MAKER_MSB:0] != st.ident.maker);
				end
				`PPDM_OFS_PART: begin
					next_st.ident.part = mrg[`PPDM_PART_MSB:0];
					clearStore = (mrg[`PPDM_PART_MSB:0] != st.ident.part);
				end
				default: ;
			endcase
		end

		// read channel
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		if (st.arReady && s_axi_arvalid) begin
			next_st.rvalid = 1'b1;
			next_st.rresp  = `PPDM_RESP_OKAY;
			next_st.rdata  = '0;
			case (s_axi_araddr)
				`PPDM_OFS_CTRL: next_st.rdata = ctrlImage(st.ctrl);
				`PPDM_OFS_PERIOD: next_st.rdata = 32'(st.periodCode);
				`PPDM_OFS_MAKER: next_st.rdata = 32'(st.ident.maker);
				`PPDM_OFS_PART: next_st.rdata = 32'(st.ident.part);
				`PPDM_OFS_PSTAT: begin
					next_st.rdata[`PPDM_UNITS_MSB:0]               = st.periodUnits;
					next_st.rdata[`PPDM_LINK_MSB:`PPDM_LINK_LSB] = st.link;
					next_st.rdata[`PPDM_FAULT_BIT]                = st.identFault;
				end
				`PPDM_OFS_SSTAT: begin
					next_st.rdata[`PPDM_SVALID_BIT]             = st.storedValid;
					next_st.rdata[`PPDM_SEN_BIT]                = st.ctrl.mode == MODE_MANUAL
						&& (st.ctrl.check == CHK_BACKUP_RESTORE || st.ctrl.check == CHK_RESTORE);
					next_st.rdata[`PPDM_ACT_MSB:`PPDM_ACT_LSB] = st.lastAction;
				end
				`PPDM_OFS_SCHK: next_st.rdata = st.storedChecksum;
				default: next_st.rresp = `PPDM_RESP_SLVERR;
			endcase
		end

		// parameter_store clears from register writes
		if (clearStore) begin
			next_st.storedValid    = 1'b0;
			next_st.storedChecksum = '0;
			next_st.lastAction     = ACT_CLEAR;
		end

		// link start-up: identity check, then store decision
		storeEnable = next_st.ctrl.mode == MODE_MANUAL
			&& (next_st.ctrl.check == CHK_BACKUP_RESTORE || next_st.ctrl.check == CHK_RESTORE);
		if (linkEvt.start && (next_st.ctrl.mode == MODE_MANUAL || next_st.ctrl.mode == MODE_AUTO)) begin
			if (next_st.ctrl.mode == MODE_MANUAL && next_st.ctrl.check != CHK_NONE
					&& devIdent != next_st.ident) begin
				next_st.identFault = 1'b1;
				next_st.link       = LINK_FAULT;
			end else begin
				next_st.identFault = 1'b0;
				next_st.link       = LINK_ACTIVE;
				next_st.startComm  = 1'b1;
				if (next_st.ctrl.check == CHK_NONE || next_st.ctrl.check == CHK_V10
						|| next_st.ctrl.check == CHK_V11) begin
					next_st.storedValid    = 1'b0;
					next_st.storedChecksum = '0;
					next_st.lastAction     = ACT_CLEAR;
				end else if (storeEnable && next_st.ctrl.check == CHK_BACKUP_RESTORE
						&& (!next_st.storedValid || linkEvt.backupReq)) begin
					next_st.doBackup       = 1'b1;
					next_st.storedValid    = 1'b1;
					next_st.storedChecksum = linkEvt.checksum;
					next_st.lastAction     = ACT_BACKUP;
				end else if (storeEnable && next_st.storedValid && !linkEvt.backupReq
						&& next_st.storedChecksum != linkEvt.checksum) begin
					next_st.doRestore  = 1'b1;
					next_st.lastAction = ACT_RESTORE;
				end else begin
					next_st.lastAction = ACT_NONE;
				end
			end
		end else if (linkEvt.down) begin
			next_st.link = LINK_IDLE;
		end

		// cyclic_payload toward the device; hold and healthy share one path
		if (upConnOk && upOutStrobe) begin
			next_st.lastOut = upOutData;
		end
		if (upConnOk || st.ctrl.pol == POL_HOLD) begin
			next_st.devOut = swapField(next_st.lastOut, st.ctrl.swap, st.ctrl.mapLen, st.ctrl.mapLen, devLen);
			next_st.devOutValid = 1'b1;
		end else if (st.ctrl.pol == POL_KEEPVALID) begin
			next_st.devOut      = '0;
			next_st.devOutValid = 1'b1;
		end else begin
			next_st.devOut      = '0;
			next_st.devOutValid = 1'b0;
		end
		next_st.upIn = swapField(devInData, st.ctrl.swap, st.ctrl.mapLen, devLen, st.ctrl.mapLen);

		// port period and cycle tick
		next_st.periodUnits = periodDecode(st.periodCode, devMinCycle);
		if (st.link == LINK_ACTIVE) begin
			if (st.subCnt == CW'(BASE_CYCLES - 1)) begin
				next_st.subCnt = '0;
				if (st.unitCnt >= st.periodUnits - 12'h001) begin
					next_st.unitCnt   = '0;
					next_st.cycleTick = 1'b1;
				end else begin
					next_st.unitCnt = st.unitCnt + 12'h001;
				end
			end else begin
				next_st.subCnt = st.subCnt + CW'(1);
			end
		end else begin
			next_st.subCnt  = '0;
			next_st.unitCnt = '0;
		end

		// one transaction of each direction at a time
		next_st.awReady = !next_st.awHeld && !next_st.bvalid;
		next_st.wReady  = !next_st.wHeld && !next_st.bvalid;
		next_st.arReady = !next_st.rvalid;
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			st <= RST_ST;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================
	// outputs
	assign s_axi_awready = st.awReady;
	assign s_axi_wready  = st.wReady;
	assign s_axi_bresp   = st.bresp;
	assign s_axi_bvalid  = st.bvalid;
	assign s_axi_arready = st.arReady;
	assign s_axi_rdata   = st.rdata;
	assign s_axi_rresp   = st.rresp;
	assign s_axi_rvalid  = st.rvalid;
	assign upInData      = st.upIn;
	assign devOutData    = st.devOut;
	assign devOutValid   = st.devOutValid;
	assign startComm     = st.startComm;
	assign identFault    = st.identFault;
	assign doBackup      = st.doBackup;
	assign doRestore     = st.doRestore;
	assign periodUnits   = st.periodUnits;
	assign cycleTick     = st.cycleTick;

	// ==========================================================
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	keep_valid_a: assert property (!upConnOk && st.ctrl.pol == POL_KEEPVALID
		|=> devOutData == '0 && devOutValid)
		else $error("clear_keep_valid output wrong");
	hold_last_a: assert property ((!upConnOk && st.ctrl.pol == POL_HOLD
		&& $stable(st.ctrl) && $stable(devLen))[*3] |-> $stable(devOutData) && devOutValid)
		else $error("hold output changed");
	mark_invalid_a: assert property (!upConnOk && st.ctrl.pol == POL_MARKINVALID
		|=> devOutData == '0 && !devOutValid)
		else $error("clear_mark_invalid output wrong");
	half_swap_a: assert property (st.ctrl.swap == SW_HALF && st.ctrl.mapLen == devLen && devLen >= 6'h02
		|=> upInData[15:0] == {$past(devInData[7:0]), $past(devInData[15:8])})
		else $error("halfword order wrong");
	full_swap_a: assert property (st.ctrl.swap == SW_FULL && st.ctrl.mapLen == ppdm_len_t'(MAP_BYTES)
		&& devLen == ppdm_len_t'(MAP_BYTES)
		|=> upInData[`PPDM_BYTE_W-1:0] == $past(devInData[DW-1 -: `PPDM_BYTE_W])
		&& upInData[DW-1 -: `PPDM_BYTE_W] == $past(devInData[`PPDM_BYTE_W-1:0]))
		else $error("full order wrong");
	word_short_a: assert property (st.ctrl.swap == SW_WORD && st.ctrl.mapLen == 6'h02 && devLen >= 6'h02
		|=> upInData[15:0] == $past(devInData[15:0]))
		else $error("two byte field swapped");
	// automatic and tiny periods both land on the floor
	auto_period_a: assert property (st.periodCode == 8'h00
		|=> periodUnits == (($past(devMinCycle) > MIN_U) ? $past(devMinCycle) : MIN_U))
		else $error("automatic period wrong");
	clamp_high_a: assert property (st.periodCode >= `PPDM_CODE_CLAMP_HI && devMinCycle < 12'h010
		|=> periodUnits == MAX_U)
		else $error("high clamp wrong");
	base_one_a: assert property (st.periodCode == 8'h7F && devMinCycle < 12'h010 |=> periodUnits == 12'd316)
		else $error("time base 01 wrong");
	// decision uses post-write control, which is the registered control one edge later
	store_gate_a: assert property (doBackup || doRestore |-> st.ctrl.mode == MODE_MANUAL
		&& (st.ctrl.check == CHK_BACKUP_RESTORE || st.ctrl.check == CHK_RESTORE))
		else $error("store action while disabled");
	start_clear_a: assert property (linkEvt.start && st.ctrl.mode == MODE_AUTO
		|=> startComm && !st.storedValid)
		else $error("store not cleared at start");
	backup_rec_a: assert property (doBackup |-> st.storedValid && st.storedChecksum == $past(linkEvt.checksum))
		else $error("backup checksum not recorded");

	backup_c: cover property (doBackup);
	restore_c: cover property (doRestore);
	hold_c: cover property (!upConnOk && st.ctrl.pol == POL_HOLD && devOutValid);
	tick_c: cover property (cycleTick);

endmodule // ppdm_top

//--- testbench/ppdm_field_dev.sv
// ==========================================================
// connected field device model
module ppdm_field_dev import ppdm_pkg::*; #(
	parameter logic [31:0] SUM = 32'h5A5A_1234
) (
	// clock and command
	input  wire logic  mclk,
	input  wire logic  kick,
	// device side
	output logic [63:0] devInData,
	output ppdm_len_t   devLen,
	output logic [11:0] devMinCycle,
	output ppdm_start_t linkEvt,
	output ppdm_ident_t devIdent
);
	timeunit 1ns;
	timeprecision 1ns;
	assign devInData   = 64'hEFCD_AB89_6745_2301;
	assign devLen      = 6'h08;
	assign devMinCycle = 12'h001;
	// identity value arbitrary, chosen to equal the expected codes after reset
	assign devIdent    = '{maker: 16'h0001, part: 24'h000001};
	logic [31:0] sum = SUM;
	// start pulse lasts one cycle, no backup request; checksum steps after every start
	always_ff @(posedge mclk) begin
		linkEvt <= '{start: kick, down: 1'b0, backupReq: 1'b0, checksum: sum};
		if (kick) begin
			sum <= sum + 32'h0000_0001;
		end
	end
endmodule // ppdm_field_dev

//--- testbench/port_process_data_manager_test.sv
module port_process_data_manager_test import ppdm_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk, reset, awValid, wValid, bReady, arValid, rReady, upConnOk, upOutStrobe, kick;
	logic awReady, wReady, bValid, arReady, rValid, devOutValid, startComm, doBackup, doRestore, idFault, tick;
	logic [7:0] awAddr, arAddr;
	logic [31:0] wData, rData, d;
	logic [1:0] bResp, rResp, r;
	logic [63:0] upOutData, upInData, devInData, devOutData;
	logic [11:0] devMinCycle, perUnits;
	ppdm_len_t devLen;
	ppdm_start_t linkEvt;
	ppdm_ident_t devIdent;
	int fails, checks, i;
	logic [7:0] codes [8] = '{8'h00, 8'h02, 8'h3F, 8'h40, 8'h7F, 8'h80, 8'hBF, 8'hC5};
	logic [11:0] units [8] = '{12'h004, 12'h004, 12'h03F, 12'h040, 12'h13C, 12'h140, 12'h530, 12'h530};
	logic [63:0] ups [4] = '{64'hEFCDAB8967452301, 64'hCDEF89AB45670123, 64'h89ABCDEF01234567, 64'h0123456789ABCDEF};
	ppdm_top #(.MAP_BYTES(8), .BASE_CYCLES(4)) u_ppdm_top (.mclk(mclk), .reset(reset),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
		.s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
		.s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
		.s_axi_rready(rReady), .upConnOk(upConnOk), .upOutStrobe(upOutStrobe), .upOutData(upOutData),
		.upInData(upInData), .devInData(devInData), .devLen(devLen), .devMinCycle(devMinCycle),
		.devOutData(devOutData), .devOutValid(devOutValid), .linkEvt(linkEvt), .devIdent(devIdent),
		.startComm(startComm), .identFault(idFault), .doBackup(doBackup), .doRestore(doRestore),
		.periodUnits(perUnits), .cycleTick(tick));
	ppdm_field_dev u_ppdm_field_dev (.mclk(mclk), .kick(kick), .devInData(devInData), .devLen(devLen),
		.devMinCycle(devMinCycle), .linkEvt(linkEvt), .devIdent(devIdent));
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// ==========================================================
	// checking and bus tasks
	task automatic end_of_test();
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [64:0] got, input logic [64:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic hang(input int n);
		if (n >= 99) begin
			fails++;
			end_of_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int n;
		awAddr <= a;
		wData <= v;
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		for (n = 0; n < 99; n++) begin
			@(posedge mclk);
			if (awReady) awValid <= 1'b0;
			if (wReady) wValid <= 1'b0;
			if (bValid) break;
		end
		bReady <= 1'b0;
		hang(n);
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		for (n = 0; n < 99; n++) begin
			@(posedge mclk);
			if (arReady) arValid <= 1'b0;
			d = rData;
			r = rResp;
			if (rValid) break;
		end
		rReady <= 1'b0;
		hang(n);
	endtask
	task automatic startLink();
		int n;
		kick <= 1'b1;
		@(posedge mclk);
		kick <= 1'b0;
		for (n = 0; n < 99 && startComm !== 1'b1; n++) @(posedge mclk);
		hang(n);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		{reset, awValid, wValid, bReady, arValid, rReady, upConnOk, upOutStrobe, kick} = 9'h100;
		{awAddr, arAddr, wData, upOutData, fails, checks} = '0;
		repeat (20) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		rd(8'h00);
		chk(d, 32'h0008_0002);
		for (i = 0; i < 8; i++) begin
			wr(8'h00, {16'h0008, 12'h000, i[1:0], 2'h0});
			wr(8'h04, {24'h0, codes[i]});
			repeat (2) @(posedge mclk);
			chk(upInData, ups[i[1:0]]);
			rd(8'h10);
			chk(d[11:0], units[i]);
			chk(perUnits, units[i]);
		end
		wr(8'h00, 32'h0002_0008);
		repeat (2) @(posedge mclk);
		chk(upInData, 64'h2301);
		// policy while the fieldbus drops
		for (i = 0; i < 3; i++) begin
			wr(8'h00, {16'h0008, 14'h0, i[1:0]});
			upConnOk <= 1'b1;
			upOutStrobe <= 1'b1;
			upOutData <= 64'h1122_3344_5566_7788;
			repeat (2) @(posedge mclk);
			{upConnOk, upOutStrobe} <= 2'h0;
			repeat (2) @(posedge mclk);
			chk({devOutValid, devOutData}, {i != 2, i == 1 ? 64'h1122_3344_5566_7788 : 64'h0});
		end
		rd(8'h1C);
		chk(r, 2'h2);
		wr(8'h00, 32'h0008_0310);
		startLink();
		chk(doBackup, 1'b1);
		rd(8'h18);
		chk(d, 32'h5A5A_1234);
		startLink();
		chk(doRestore, 1'b1);
		wr(8'h00, 32'h0008_0410);
		startLink();
		chk(doRestore, 1'b1);
		wr(8'h00, 32'h0008_0320);
		rd(8'h00);
		chk(d, 32'h0008_0020);
		rd(8'h14);
		chk(d[1:0], 2'h0);
		wr(8'h00, 32'h0008_0310);
		startLink();
		chk(doBackup, 1'b1);
		wr(8'h08, 32'h0000_0002);
		rd(8'h14);
		chk(d[0], 1'b0);
		kick <= 1'b1;
		@(posedge mclk);
		kick <= 1'b0;
		repeat (2) @(posedge mclk);
		chk({idFault, startComm}, 2'h2);
		wr(8'h00, 32'h0008_0020);
		wr(8'h04, 32'h0000_0000);
		startLink();
		chk(idFault, 1'b0);
		for (i = 0; i < 99 && tick !== 1'b1; i++) @(posedge mclk);
		hang(i);
		@(posedge mclk);
		for (i = 1; i < 99 && tick !== 1'b1; i++) @(posedge mclk);
		hang(i);
		chk(i, 16);
		end_of_test();
	end
endmodule // port_process_data_manager_test
